//--- bench/fcp_fault_panel_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module fcp_fault_panel_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, io_interlock_inh, auto_reread, orig_dir, err_delete_lamp, irq;
    logic [6:0] in_sync_u = 7'h01, in_sync_b = 7'h01, out_sync_u = 7'h01, out_sync_b = 7'h01;
    logic [6:0] fast_bus_u = 7'h01, fast_bus_b = 7'h01;
    logic in_sync_valid = 0, out_sync_valid = 0, io_read_exec = 0, io_write_exec = 0;
    logic read_interlock = 0, write_interlock = 0, instr_dir = 0, ioc_dir = 0;
    logic fast_bus_valid = 0, reread_relay = 0, tape_dir_restored = 0, ft_valid = 0;
    logic timeout_flop_a = 0, timeout_flop_b = 0, fault_a = 0, fault_b = 0;
    logic loop_barred, delay27, loop_dup_a, loop_dup_b, mem_sel_active = 0;
    logic [3:0] reread_step_pos = 4'h1;
    logic [7:0] ft_sig_u = 8'h01, ft_sig_b = 8'h01;
    logic [9:0] ft_inter_lines = 10'h001, mem_sel_hund = 10'h001, mem_sel_tens = 10'h001;
    logic [15:0] fault_flags, check_out, delete_sel;
    int err_total = 0, n_checks = 0, m;
    fcp_fault_panel dut_u (.*);
    fcp_panel_model pm_u (.*);
    // Free-running system clock
    always #50 pclk = ~pclk;
    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20)
            final_report(1);
        rv = prdata;
        se = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Let n edges pass, then sample settled outputs
    task automatic tk(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic final_report(input int to);
        err_total += to;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h00, 0); `CHK(rv, 32'h0)
        apb(0, 8'h14, 0); `CHK(se, 1'b1)
        // Even characters on both synchronizers, each cleared by its own command
        {in_sync_valid, out_sync_valid, in_sync_u, out_sync_b} <= {2'b11, 7'h03, 7'h00};
        tk(1); `CHK(fault_flags[3:0], 4'b1001)
        @(posedge pclk) {in_sync_valid, out_sync_valid} <= 2'b00;
        apb(1, 8'h04, 32'h1); #1 `CHK(fault_flags[3:0], 4'b1000)
        apb(1, 8'h04, 32'h2); #1 `CHK(fault_flags[3:0], 4'b0000)
        // Tape read with no interlock set
        @(posedge pclk) io_read_exec <= 1'b1;
        tk(2); `CHK({fault_flags[4], io_interlock_inh}, 2'b11)
        @(posedge pclk) io_read_exec <= 1'b0;
        apb(1, 8'h04, 32'h4); tk(1); `CHK(fault_flags[4], 1'b0)
        // Even unbarred char and bus mismatch, then irq unmask and clear
        @(posedge pclk) {fast_bus_valid, fast_bus_u, fast_bus_b} <= {1'b1, 7'h03, 7'h01};
        tk(1); `CHK(fault_flags[7:5], 3'b101)
        @(posedge pclk) fast_bus_valid <= 1'b0;
        tk(1); `CHK(check_out[7], 1'b1)
        apb(1, 8'h10, 32'h80); tk(1); `CHK(irq, 1'b1)
        apb(1, 8'h0C, 32'h80); tk(1); `CHK(irq, 1'b0)
        apb(1, 8'h04, 32'h8); #1 `CHK(fault_flags[7:5], 3'b000)
        // Timeout pair disagree; start must not clear it
        @(posedge pclk) timeout_flop_a <= 1'b1;
        tk(1);
        @(posedge pclk) timeout_flop_a <= 1'b0;
        apb(1, 8'h04, 32'h8); #1 `CHK(fault_flags[10], 1'b1)
        apb(1, 8'h00, 32'h200); tk(2); `CHK({check_out[10], err_delete_lamp}, 2'b01)
        @(posedge pclk) {reread_relay, reread_step_pos} <= {1'b1, 4'h2};
        tk(2); `CHK({auto_reread, orig_dir}, 2'b11)
        @(posedge pclk) {reread_relay, reread_step_pos, tape_dir_restored} <= {1'b0, 4'h3, 1'b1};
        tk(2); `CHK({auto_reread, orig_dir}, 2'b01)
        // Both cycling faults under each of the three panel settings
        @(posedge pclk) {fault_a, fault_b} <= 2'b11;
        for (m = 0; m < 3; m++)
        begin
            apb(1, 8'h00, m);
            tk(2);
            `CHK({check_out[9:8], delete_sel[9:8], err_delete_lamp}, 5'b11000 >> (2 * m))
        end
        @(posedge pclk) {fault_a, fault_b} <= 2'b00;
        apb(1, 8'h04, 32'h10); #1 `CHK(fault_flags[9:8], 2'b00)
        apb(1, 8'h00, 32'h800); tk(3); `CHK(fault_flags[9:8], 2'b01)
        apb(1, 8'h00, 32'h0);
        apb(1, 8'h04, 32'h10);
        apb(1, 8'h04, 32'h20); tk(2); `CHK(fault_flags[9:8], 2'b10)
        // Function-table and selector checks, routed then inhibited; intermediate-line check inhibited, then normal
        @(posedge pclk) {ft_valid, ft_sig_u, ft_inter_lines} <= {1'b1, 8'h03, 10'h003};
        {mem_sel_active, mem_sel_hund, mem_sel_tens} <= {1'b1, 10'h011, 10'h000};
        tk(1); `CHK(fault_flags[15:11], 5'h1D)
        @(posedge pclk) {ft_valid, ft_inter_lines, mem_sel_active} <= {1'b0, 10'h001, 1'b0};
        apb(1, 8'h00, 32'h414);
        tk(2); `CHK({delete_sel[15:11], err_delete_lamp}, 6'h33)
        `CHK(check_out[15:11], 5'h00)
        apb(1, 8'h00, 32'h28);
        tk(2); `CHK({check_out[15:11], err_delete_lamp}, 6'h09)
        `CHK(delete_sel[15:11], 5'h00)
        apb(1, 8'h04, 32'h8); #1 `CHK(fault_flags[15:11], 5'h00)
        // Write with its interlock set but tape direction disagreeing
        @(posedge pclk) {io_write_exec, write_interlock, instr_dir} <= 3'h7;
        tk(1); `CHK(io_interlock_inh, 1'b1)
        final_report(0);
    end
endmodule
`default_nettype wire

//--- bench/fcp_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module fcp_panel_model (
    input  wire logic pclk,        // System clock
    input  wire logic fault_a,     // Break the barred loop
    input  wire logic fault_b,     // Break one duplicate loop
    output logic      loop_barred, // Barred loop output
    output logic      delay27,     // Long delay output
    output logic      loop_dup_a,  // Duplicate loop A
    output logic      loop_dup_b   // Duplicate loop B
);
    logic ph = 1'b0;
    // Loops circulate in step; toggling keeps a stuck compare visible
    always_ff @(posedge pclk) ph <= ~ph;
    assign delay27     = ph;
    assign loop_dup_a  = ph;
    assign loop_dup_b  = ph ^ fault_b;
    assign loop_barred = ph ^ fault_a;
endmodule
`default_nettype wire

//--- logic/fcp_check_gate.sv
`timescale 1ns/1ps
`default_nettype none
module fcp_check_gate (
    input  wire logic              err,   // Latched check flag
    input  wire fcp_pkg::fcp_mode_t mode, // Panel setting
    output logic                   pass,  // Normal checker output
    output logic                   route, // Output to delete selector
    output logic                   lamp   // Error-delete indicator request
);
    // Steer one checker output; an inhibited gate drops the error entirely
    always_comb
    begin
        pass  = 1'b0;
        route = 1'b0;
        lamp  = 1'b0;
        case (mode)
            fcp_pkg::MODE_ROUTE:   route = err;
            fcp_pkg::MODE_INHIBIT: lamp  = 1'b1;
            default:               pass  = err;
        endcase
    end
endmodule
`default_nettype wire

//--- logic/fcp_fault_panel.sv
// How it works
// RULE1 - Input-synchronizer parity flags, unbarred and barred, set on even count until its clear
// RULE2 - Output-synchronizer parity flags, set on even count until its clear
// RULE3 - Interlock fault on unlocked read/write or direction mismatch; held, gate inhibited
// RULE4 - Fast bus parity flags, unbarred and barred, held until start
// RULE5 - Duplicate fast bus mismatch flag held until start
// RULE6 - Auto re-read status follows the re-read relay
// RULE7 - Original-direction status on restored direction or even stepping position
// RULE8 - A-type insert suppresses barred loop input to the barred compare adder
// RULE9 - B-type insert adds one pulse to duplicate compare adder only
// RULE10 - Timeout flop pair disagreement flagged; inhibit blocks output and lights lamp
// RULE11 - A-type error when barred loops disagree with the long delay
// RULE12 - B-type error when duplicate loops disagree; separate indicators
// RULE13 - Cycle check setting: normal, routed to delete selector, or inhibited with lamp
// RULE14 - Function-table output checkers flag even count; route or inhibit with lamp
// RULE15 - More than one intermediate line flags error; inhibit blocks it, lights lamp
// RULE16 - Memory-selector checkers normal, routed or inhibited; inhibit lights lamp
// RULE17 - Flags are clocked, set-dominant, cleared only by their own clears
// RULE18 - Timeout disagreement flag has no clear besides reset
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fcp_fault_panel (
    input  wire logic                     pclk,              // System clock
    input  wire logic                     presetn,           // Async reset, low
    input  wire logic                     psel,              // APB select
    input  wire logic                     penable,           // APB enable
    input  wire logic                     pwrite,            // APB direction
    input  wire logic [7:0]               paddr,             // APB byte address
    input  wire logic [31:0]              pwdata,            // APB write data
    output logic [31:0]                   prdata,            // APB read data
    output logic                          pready,            // APB ready
    output logic                          pslverr,           // APB error
    input  wire logic [fcp_pkg::CHAR_W-1:0] in_sync_u,       // Input sync, unbarred
    input  wire logic [fcp_pkg::CHAR_W-1:0] in_sync_b,       // Input sync, barred
    input  wire logic                     in_sync_valid,     // Input char strobe
    input  wire logic [fcp_pkg::CHAR_W-1:0] out_sync_u,      // Output sync, unbarred
    input  wire logic [fcp_pkg::CHAR_W-1:0] out_sync_b,      // Output sync, barred
    input  wire logic                     out_sync_valid,    // Output char strobe
    input  wire logic                     io_read_exec,      // Tape read executing
    input  wire logic                     io_write_exec,     // Tape write executing
    input  wire logic                     read_interlock,    // Read interlock set
    input  wire logic                     write_interlock,   // Write interlock set
    input  wire logic                     instr_dir,         // Direction from instruction
    input  wire logic                     ioc_dir,           // Direction from I/O control
    input  wire logic [fcp_pkg::CHAR_W-1:0] fast_bus_u,      // Fast bus, unbarred
    input  wire logic [fcp_pkg::CHAR_W-1:0] fast_bus_b,      // Fast bus, barred
    input  wire logic                     fast_bus_valid,    // Fast bus strobe
    input  wire logic                     reread_relay,      // Re-read relay energized
    input  wire logic                     tape_dir_restored, // Direction back to error-time
    input  wire logic [3:0]               reread_step_pos,   // Re-read stepping position
    input  wire logic                     loop_barred,       // Barred 7/13-pulse loop output
    input  wire logic                     delay27,           // 27-pulse delay output
    input  wire logic                     loop_dup_a,        // Duplicate loop A
    input  wire logic                     loop_dup_b,        // Duplicate loop B
    input  wire logic                     timeout_flop_a,    // Timeout flop A
    input  wire logic                     timeout_flop_b,    // Timeout flop B
    input  wire logic [fcp_pkg::FT_W-1:0] ft_sig_u,          // Function signals, unbarred
    input  wire logic [fcp_pkg::FT_W-1:0] ft_sig_b,          // Function signals, barred
    input  wire logic                     ft_valid,          // Function signals valid
    input  wire logic [fcp_pkg::SEL_W-1:0] ft_inter_lines,   // Intermediate lines
    input  wire logic [fcp_pkg::SEL_W-1:0] mem_sel_hund,     // Hundreds selector lines
    input  wire logic [fcp_pkg::SEL_W-1:0] mem_sel_tens,     // Tens selector lines
    input  wire logic                     mem_sel_active,    // Memory selection in use
    output logic [fcp_pkg::NFLAG-1:0]     fault_flags,       // Indicator flags
    output logic [fcp_pkg::NFLAG-1:0]     check_out,         // Normal checker outputs
    output logic [fcp_pkg::NFLAG-1:0]     delete_sel,        // Routed to delete selector
    output logic                          io_interlock_inh,  // Interlock gate inhibited
    output logic                          auto_reread,       // Auto re-read status
    output logic                          orig_dir,          // Original direction status
    output logic                          err_delete_lamp,   // Error-delete indicator
    output logic                          irq                // Interrupt, high level
);
    fcp_pkg::fcp_state_t s_r, s_nxt;
    fcp_pkg::fcp_mode_t  mode_v [fcp_pkg::NFLAG];
    logic [fcp_pkg::NFLAG-1:0] g_pass, g_route, g_lamp;
    logic [fcp_pkg::NFLAG-1:0] set_v, clr_v;
    logic wr_en, setup, is_clr, os_clr, gen_clr, start_p, cu_clr, ins_b;
    logic a_err, b_err;

    // Even pulse count on a synchronizer or bus character
    function automatic logic char_even(input logic [fcp_pkg::CHAR_W-1:0] v);
        char_even = ~^v;
    endfunction

    // More than one line raised
    function automatic logic multi_hot(input logic [fcp_pkg::SEL_W-1:0] v);
        multi_hot = (v & (v - fcp_pkg::SEL_ONE)) != '0;
    endfunction

    // Selector fault: none, or more than one line
    function automatic logic sel_bad(input logic [fcp_pkg::SEL_W-1:0] v);
        sel_bad = (v == '0) || multi_hot(v);
    endfunction

    // Two-position switch: normal or inhibit only
    function automatic fcp_pkg::fcp_mode_t inh_mode(input logic inh);
        inh_mode = inh ? fcp_pkg::MODE_INHIBIT : fcp_pkg::MODE_NORMAL;
    endfunction

    // Bus strobes; clears and inserts act at the access edge of a command write
    assign wr_en   = psel & penable & pwrite;
    assign setup   = psel & ~penable;
    assign is_clr  = wr_en && paddr == fcp_pkg::OFF_CMD && pwdata[fcp_pkg::K_IS];
    assign os_clr  = wr_en && paddr == fcp_pkg::OFF_CMD && pwdata[fcp_pkg::K_OS];
    assign gen_clr = wr_en && paddr == fcp_pkg::OFF_CMD && pwdata[fcp_pkg::K_GEN];
    assign start_p = wr_en && paddr == fcp_pkg::OFF_CMD && pwdata[fcp_pkg::K_START];
    assign cu_clr  = wr_en && paddr == fcp_pkg::OFF_CMD && pwdata[fcp_pkg::K_CU];
    assign ins_b   = wr_en && paddr == fcp_pkg::OFF_CMD && pwdata[fcp_pkg::K_INSB];

    // Cycling-unit comparisons; inserts touch only the check path, never the loops
    assign a_err = (loop_barred & ~s_r.ctrl[fcp_pkg::C_INSA]) ^ delay27; // RULE8 RULE11
    assign b_err = (loop_dup_a ^ loop_dup_b) ^ ins_b;                    // RULE9 RULE12

    // Raw check conditions sampled this cycle
    always_comb
    begin
        set_v = '0;
        set_v[fcp_pkg::F_IS_U] = in_sync_valid & char_even(in_sync_u);    // RULE1
        set_v[fcp_pkg::F_IS_B] = in_sync_valid & char_even(in_sync_b);    // RULE1
        set_v[fcp_pkg::F_OS_U] = out_sync_valid & char_even(out_sync_u);  // RULE2
        set_v[fcp_pkg::F_OS_B] = out_sync_valid & char_even(out_sync_b);  // RULE2
        set_v[fcp_pkg::F_ILK]  = (io_read_exec & ~read_interlock)
                               | (io_write_exec & ~write_interlock)
                               | ((io_read_exec | io_write_exec) & (instr_dir ^ ioc_dir)); // RULE3
        set_v[fcp_pkg::F_FB_U] = fast_bus_valid & char_even(fast_bus_u);  // RULE4
        set_v[fcp_pkg::F_FB_B] = fast_bus_valid & char_even(fast_bus_b);  // RULE4
        set_v[fcp_pkg::F_FBCMP] = fast_bus_valid & (fast_bus_u != fast_bus_b); // RULE5
        set_v[fcp_pkg::F_CU_A] = a_err;                                   // RULE11
        set_v[fcp_pkg::F_CU_B] = b_err;                                   // RULE12
        set_v[fcp_pkg::F_TO]   = timeout_flop_a ^ timeout_flop_b;         // RULE10
        set_v[fcp_pkg::F_FTO_U] = ft_valid & ~^ft_sig_u;                  // RULE14
        set_v[fcp_pkg::F_FTO_B] = ft_valid & ~^ft_sig_b;                  // RULE14
        set_v[fcp_pkg::F_FTI]  = multi_hot(ft_inter_lines);               // RULE15
        set_v[fcp_pkg::F_MS_H] = mem_sel_active & sel_bad(mem_sel_hund);  // RULE16
        set_v[fcp_pkg::F_MS_T] = mem_sel_active & sel_bad(mem_sel_tens);  // RULE16
    end

    // Clear sources per flag; the timeout flag has none
    always_comb
    begin
        clr_v = '0;
        clr_v[fcp_pkg::F_IS_U] = is_clr;                     // RULE1
        clr_v[fcp_pkg::F_IS_B] = is_clr;                     // RULE1
        clr_v[fcp_pkg::F_OS_U] = os_clr;                     // RULE2
        clr_v[fcp_pkg::F_OS_B] = os_clr;                     // RULE2
        clr_v[fcp_pkg::F_ILK]  = gen_clr | is_clr | os_clr;  // RULE3
        clr_v[fcp_pkg::F_FB_U] = start_p;                    // RULE4
        clr_v[fcp_pkg::F_FB_B] = start_p;                    // RULE4
        clr_v[fcp_pkg::F_FBCMP] = start_p;                   // RULE5
        clr_v[fcp_pkg::F_CU_A] = start_p | cu_clr;
        clr_v[fcp_pkg::F_CU_B] = start_p | cu_clr;
        clr_v[fcp_pkg::F_TO]   = 1'b0;                       // RULE18
        clr_v[fcp_pkg::F_FTO_U] = start_p;
        clr_v[fcp_pkg::F_FTO_B] = start_p;
        clr_v[fcp_pkg::F_FTI]  = start_p;
        clr_v[fcp_pkg::F_MS_H] = start_p;
        clr_v[fcp_pkg::F_MS_T] = start_p;
    end

    // Panel setting for each checker output gate
    always_comb
    begin
        for (int i = 0; i < fcp_pkg::NFLAG; i++)
            mode_v[i] = fcp_pkg::MODE_NORMAL;
        mode_v[fcp_pkg::F_FB_U]  = fcp_pkg::fcp_mode_t'(s_r.ctrl[fcp_pkg::C_FBOE +: 2]);
        mode_v[fcp_pkg::F_FB_B]  = fcp_pkg::fcp_mode_t'(s_r.ctrl[fcp_pkg::C_FBOE +: 2]);
        mode_v[fcp_pkg::F_FBCMP] = inh_mode(s_r.ctrl[fcp_pkg::C_FBCMP]);
        mode_v[fcp_pkg::F_CU_A]  = fcp_pkg::fcp_mode_t'(s_r.ctrl[fcp_pkg::C_CYC +: 2]);  // RULE13
        mode_v[fcp_pkg::F_CU_B]  = fcp_pkg::fcp_mode_t'(s_r.ctrl[fcp_pkg::C_CYC +: 2]);  // RULE13
        mode_v[fcp_pkg::F_TO]    = inh_mode(s_r.ctrl[fcp_pkg::C_TO]);                    // RULE10
        mode_v[fcp_pkg::F_FTO_U] = fcp_pkg::fcp_mode_t'(s_r.ctrl[fcp_pkg::C_FTO +: 2]);  // RULE14
        mode_v[fcp_pkg::F_FTO_B] = fcp_pkg::fcp_mode_t'(s_r.ctrl[fcp_pkg::C_FTO +: 2]);  // RULE14
        mode_v[fcp_pkg::F_FTI]   = inh_mode(s_r.ctrl[fcp_pkg::C_FTI]);                   // RULE15
        mode_v[fcp_pkg::F_MS_H]  = fcp_pkg::fcp_mode_t'(s_r.ctrl[fcp_pkg::C_TANK +: 2]); // RULE16
        mode_v[fcp_pkg::F_MS_T]  = fcp_pkg::fcp_mode_t'(s_r.ctrl[fcp_pkg::C_TANK +: 2]); // RULE16
    end

    // One output gate per flag
    for (genvar g = 0; g < fcp_pkg::NFLAG; g++)
    begin : gate
        fcp_check_gate u_gate (
            .err   (s_r.flags[g]),
            .mode  (mode_v[g]),
            .pass  (g_pass[g]),
            .route (g_route[g]),
            .lamp  (g_lamp[g])
        );
    end

    // Next state: flags, interrupts, control and bus read data
    always_comb
    begin
        s_nxt = s_r;
        // Set wins over clear, so an error in the clear cycle survives
        s_nxt.flags = (s_r.flags & ~clr_v) | set_v;                       // RULE17
        s_nxt.irq_stat = s_r.irq_stat | (set_v & ~s_r.flags);
        s_nxt.auto_rr  = reread_relay;                                    // RULE6
        s_nxt.orig_dir = tape_dir_restored | ~reread_step_pos[0];         // RULE7
        s_nxt.chk_out  = g_pass;
        s_nxt.del_sel  = g_route;                                         // RULE13
        s_nxt.lamp     = |g_lamp;                                         // RULE10
        if (wr_en)
        begin
            if (paddr == fcp_pkg::OFF_CTRL)
                s_nxt.ctrl = pwdata[11:0];
            else if (paddr == fcp_pkg::OFF_IRQS)
                s_nxt.irq_stat = (s_r.irq_stat & ~pwdata[15:0]) | (set_v & ~s_r.flags);
            else if (paddr == fcp_pkg::OFF_IRQM)
                s_nxt.irq_mask = pwdata[15:0];
        end
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
        // Read data is captured in setup so the zero-wait access sees it from a flop
        if (setup)
        begin
            s_nxt.prdata  = '0;
            s_nxt.pslverr = 1'b0;
            if (paddr == fcp_pkg::OFF_CTRL)
                s_nxt.prdata[11:0] = s_r.ctrl;
            else if (paddr == fcp_pkg::OFF_CMD)
                s_nxt.prdata = '0;
            else if (paddr == fcp_pkg::OFF_STAT)
            begin
                s_nxt.prdata[15:0] = s_r.flags;
                s_nxt.prdata[fcp_pkg::S_RR]   = s_r.auto_rr;
                s_nxt.prdata[fcp_pkg::S_OD]   = s_r.orig_dir;
                s_nxt.prdata[fcp_pkg::S_LAMP] = s_r.lamp;
            end
            else if (paddr == fcp_pkg::OFF_IRQS)
                s_nxt.prdata[15:0] = s_r.irq_stat;
            else if (paddr == fcp_pkg::OFF_IRQM)
                s_nxt.prdata[15:0] = s_r.irq_mask;
            else
                s_nxt.pslverr = 1'b1;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r          <= '0;
            s_r.ctrl     <= fcp_pkg::CTRL_RST;
            s_r.irq_mask <= fcp_pkg::MASK_RST;
        end
        else
            s_r <= s_nxt;
    end

    // Outputs
    assign prdata           = s_r.prdata;
    assign pready           = 1'b1;
    assign pslverr          = s_r.pslverr;
    assign fault_flags      = s_r.flags;
    assign check_out        = s_r.chk_out;
    assign delete_sel       = s_r.del_sel;
    assign io_interlock_inh = s_r.flags[fcp_pkg::F_ILK]; // RULE3
    assign auto_reread      = s_r.auto_rr;
    assign orig_dir         = s_r.orig_dir;
    assign err_delete_lamp  = s_r.lamp;
    assign irq              = s_r.irq;

    // Checks on the flag logic
    sequence s_is_even;
        in_sync_valid && !is_clr && (~^in_sync_u);
    endsequence

    property p_is_par;
        @(posedge pclk) disable iff (!presetn)
        s_is_even |=> fault_flags[fcp_pkg::F_IS_U];
    endproperty
    a_is_par: assert property (p_is_par) else $error("input parity flag missed"); // RULE1

    property p_os_hold;
        @(posedge pclk) disable iff (!presetn)
        fault_flags[fcp_pkg::F_OS_B] && !os_clr |=> fault_flags[fcp_pkg::F_OS_B];
    endproperty
    a_os_hold: assert property (p_os_hold) else $error("output parity flag dropped"); // RULE2

    property p_ilk;
        @(posedge pclk) disable iff (!presetn)
        (io_write_exec && !write_interlock) |=> io_interlock_inh;
    endproperty
    a_ilk: assert property (p_ilk) else $error("interlock fault missed"); // RULE3

    sequence s_start_clean;
        start_p && !fast_bus_valid;
    endsequence

    property p_fb_clear;
        @(posedge pclk) disable iff (!presetn)
        s_start_clean |=> !fault_flags[fcp_pkg::F_FB_U] && !fault_flags[fcp_pkg::F_FBCMP];
    endproperty
    a_fb_clear: assert property (p_fb_clear) else $error("start did not clear bus flags"); // RULE4

    property p_fb_cmp;
        @(posedge pclk) disable iff (!presetn)
        fast_bus_valid && (fast_bus_u != fast_bus_b) |=> fault_flags[fcp_pkg::F_FBCMP];
    endproperty
    a_fb_cmp: assert property (p_fb_cmp) else $error("bus mismatch missed"); // RULE5

    property p_rr;
        @(posedge pclk) disable iff (!presetn)
        reread_relay |=> auto_reread;
    endproperty
    a_rr: assert property (p_rr) else $error("re-read status missing"); // RULE6

    property p_odir;
        @(posedge pclk) disable iff (!presetn)
        !reread_step_pos[0] |=> orig_dir;
    endproperty
    a_odir: assert property (p_odir) else $error("original direction missing"); // RULE7

    property p_ins_a;
        @(posedge pclk) disable iff (!presetn)
        s_r.ctrl[fcp_pkg::C_INSA] && loop_barred && delay27 |=> fault_flags[fcp_pkg::F_CU_A];
    endproperty
    a_ins_a: assert property (p_ins_a) else $error("A insert gave no error"); // RULE8

    property p_cu_b;
        @(posedge pclk) disable iff (!presetn)
        (loop_dup_a != loop_dup_b) && !ins_b |=> fault_flags[fcp_pkg::F_CU_B];
    endproperty
    a_cu_b: assert property (p_cu_b) else $error("B error missed"); // RULE12

    property p_to_hold;
        @(posedge pclk) disable iff (!presetn)
        fault_flags[fcp_pkg::F_TO] |=> fault_flags[fcp_pkg::F_TO] [*2];
    endproperty
    a_to_hold: assert property (p_to_hold) else $error("timeout flag cleared"); // RULE18

    property p_cyc_inh;
        @(posedge pclk) disable iff (!presetn)
        s_r.ctrl[fcp_pkg::C_CYC +: 2] == 2'h2 |=>
            err_delete_lamp && !delete_sel[fcp_pkg::F_CU_A] && !check_out[fcp_pkg::F_CU_B];
    endproperty
    a_cyc_inh: assert property (p_cyc_inh) else $error("cycle check not inhibited"); // RULE13

    property p_fti;
        @(posedge pclk) disable iff (!presetn)
        multi_hot(ft_inter_lines) |=> fault_flags[fcp_pkg::F_FTI];
    endproperty
    a_fti: assert property (p_fti) else $error("intermediate line fault missed"); // RULE15

    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        start_p && fast_bus_valid && (fast_bus_u != fast_bus_b) |=> fault_flags[fcp_pkg::F_FBCMP];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a set"); // RULE17
endmodule
`default_nettype wire

//--- logic/fcp_pkg.sv
`default_nettype none
package fcp_pkg;
    // Data path widths
    localparam int CHAR_W = 7;
    localparam int FT_W   = 8;
    localparam int SEL_W  = 10;
    localparam int NFLAG  = 16;
    localparam logic [SEL_W-1:0] SEL_ONE = 10'h001;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CMD  = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQS = 8'h0C;
    localparam logic [7:0] OFF_IRQM = 8'h10;

    // Reset values
    localparam logic [11:0] CTRL_RST = 12'h000;
    localparam logic [15:0] MASK_RST = 16'h0000;

    // Control register fields
    localparam int C_CYC   = 0;
    localparam int C_FTO   = 2;
    localparam int C_TANK  = 4;
    localparam int C_FBOE  = 6;
    localparam int C_FBCMP = 8;
    localparam int C_TO    = 9;
    localparam int C_FTI   = 10;
    localparam int C_INSA  = 11;

    // Command register bits, write one to pulse
    localparam int K_IS    = 0;
    localparam int K_OS    = 1;
    localparam int K_GEN   = 2;
    localparam int K_START = 3;
    localparam int K_CU    = 4;
    localparam int K_INSB  = 5;

    // Status register extra bits above the flags
    localparam int S_RR   = 16;
    localparam int S_OD   = 17;
    localparam int S_LAMP = 18;

    // Flag positions
    localparam int F_IS_U  = 0;
    localparam int F_IS_B  = 1;
    localparam int F_OS_U  = 2;
    localparam int F_OS_B  = 3;
    localparam int F_ILK   = 4;
    localparam int F_FB_U  = 5;
    localparam int F_FB_B  = 6;
    localparam int F_FBCMP = 7;
    localparam int F_CU_A  = 8;
    localparam int F_CU_B  = 9;
    localparam int F_TO    = 10;
    localparam int F_FTO_U = 11;
    localparam int F_FTO_B = 12;
    localparam int F_FTI   = 13;
    localparam int F_MS_H  = 14;
    localparam int F_MS_T  = 15;

    // Checker output setting
    typedef enum logic [1:0] {MODE_NORMAL, MODE_ROUTE, MODE_INHIBIT} fcp_mode_t;

    typedef struct packed {
        logic [NFLAG-1:0] flags;
        logic [NFLAG-1:0] irq_stat;
        logic [NFLAG-1:0] irq_mask;
        logic [11:0]      ctrl;
        logic [31:0]      prdata;
        logic             pslverr;
        logic             auto_rr;
        logic             orig_dir;
        logic [NFLAG-1:0] chk_out;
        logic [NFLAG-1:0] del_sel;
        logic             lamp;
        logic             irq;
    } fcp_state_t;
endpackage
`default_nettype wire
